// ==== shared/bmr_pkg.sv ====
// constants, register map and types of the boot map and reset source block
// What this block does
// - map select one mirrors SRAM at the bottom region from address zero.
// - every kind of reset clears map select, restoring non-volatile memory at bottom.
// - clearing map select puts non-volatile memory back at address zero.
// - mirrored bottom region covers all exception vectors up to 0x00000020.
// - after reset with boot mode pin high, run kernel then branch to zero.
// - factory kernel is hidden; user code cannot access it.
// - four reset sources: external pin, power-on, watchdog expiry, software.
// - an external reset sets no source flag; the flags keep their earlier values.
// - power-on reset sets flag bit 0.
// - watchdog timeout reset sets flag bit 1.
// - writing one to flag bit 2 forces a reset and leaves bit set.
// - apart from power-on reset, which clears bits 1 and 2, a flag clears only by writing one to its clear register bit.
// - clearing must cover all set flags, else a reset event occurs.
package bmr_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_MAP = 8'h00;
    localparam logic [7:0] OFS_FLAGS = 8'h04;
    localparam logic [7:0] OFS_CLEAR = 8'h08;
    localparam logic [7:0] OFS_IRQ_STA = 8'h0c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFS_BOOT = 8'h14;
    // reset source flag field
    localparam int FLAGS_W = 3;
    localparam int FLAG_POR = 0;
    localparam int FLAG_WDT = 1;
    localparam int FLAG_SW = 2;
    localparam logic [2:0] FLAGS_POR_VAL = 3'h1;
    localparam int MAP_BIT = 0;
    localparam logic MAP_RESET = 1'b0;
    // interrupt event field
    localparam int IRQ_W = 4;
    localparam int IRQ_EXT = 0;
    localparam int IRQ_WDT = 1;
    localparam int IRQ_SW = 2;
    localparam int IRQ_BADCLR = 3;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    // address regions
    localparam logic [31:0] VECTOR_LAST = 32'h0000_0020;
    localparam logic [31:0] MIRROR_END = 32'h0000_07ff;
    localparam logic [31:0] KERNEL_BASE = 32'h000f_f800;
    localparam logic [31:0] KERNEL_END = 32'h000f_ffff;
    localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;
    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int HOLD_NS = 200;
    localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int KERNEL_NS = 20000;
    localparam int KERNEL_CYC = (KERNEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 10;
    typedef enum logic [1:0] {
        BOOT_HOLD = 2'b00,
        BOOT_KERNEL = 2'b01,
        BOOT_RUN = 2'b10
    } bmr_boot_t;
endpackage

// ==== hw/bmr_top.sv ====
// boot memory map select, reset source flags and reset sequencer
`timescale 1ns/1ns
module bmr_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ext_reset_n,
    input wire logic boot_mode_pin,
    input wire logic wdt_expire,
    input wire logic [31:0] cpu_addr,
    output logic core_reset,
    output logic kernel_run,
    output logic vector_branch,
    output logic remap_sram,
    output logic bottom_sram,
    output logic bottom_nvm,
    output logic kernel_sel,
    output logic kernel_fault,
    output logic irq
);
    localparam logic [9:0] HOLD_LAST = 10'(bmr_pkg::HOLD_CYC - 1);
    localparam logic [9:0] KERNEL_LAST = 10'(bmr_pkg::KERNEL_CYC - 1);

    // register offset match on the word address
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr[7:2] == ofs[7:2]);
    endfunction

    logic ext_meta;
    logic ext_sync;
    logic ext_prev;
    logic boot_meta;
    logic boot_sync;
    logic [2:0] flags;
    logic [3:0] irq_sta;
    logic [3:0] irq_mask;
    bmr_pkg::bmr_boot_t state;
    logic [9:0] cnt;
    logic wr;
    logic sw_trig;
    logic clr_wr;
    logic bad_clr;
    logic ext_fall;
    logic chip_trig;
    logic [2:0] next_flags;
    logic [3:0] next_irq_sta;
    logic [3:0] irq_set;
    logic mirror_hit;
    logic kernel_hit;

    // two-stage synchronisers for the pins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ext_meta <= 1'b1;
            ext_sync <= 1'b1;
            ext_prev <= 1'b1;
            boot_meta <= 1'b0;
            boot_sync <= 1'b0;
        end else begin
            ext_meta <= ext_reset_n;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
            boot_meta <= boot_mode_pin;
            boot_sync <= boot_meta;
        end
    end

    // bus write strobe, taken in the cycle the ack is raised
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
    assign sw_trig = wr & hit(wb_adr_i, bmr_pkg::OFS_FLAGS)
        & wb_dat_i[bmr_pkg::FLAG_SW];
    assign clr_wr = wr & hit(wb_adr_i, bmr_pkg::OFS_CLEAR);
    // a clear that leaves any set flag standing is itself a reset event
    assign bad_clr = clr_wr & (|(flags & ~wb_dat_i[2:0]));
    assign ext_fall = ext_prev & ~ext_sync;
    // external pin holds the chip in reset for as long as it is low
    assign chip_trig = ~ext_sync | wdt_expire | sw_trig | bad_clr;

    // flag update: hardware sets win over a clear in the same cycle
    always_comb begin
        next_flags = flags;
        if (clr_wr) begin
            next_flags = flags & ~wb_dat_i[2:0];
        end
        next_flags[bmr_pkg::FLAG_WDT] = next_flags[bmr_pkg::FLAG_WDT]
            | wdt_expire;
        next_flags[bmr_pkg::FLAG_SW] = next_flags[bmr_pkg::FLAG_SW]
            | sw_trig;
    end

    // flags: only the power-on reset reinitialises them; external sets none
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flags <= bmr_pkg::FLAGS_POR_VAL;
        end else begin
            flags <= next_flags;
        end
    end

    // map select: any reset returns non-volatile memory to the bottom
    always_ff @(posedge ref_clk) begin
        if (rst || chip_trig) begin
            remap_sram <= bmr_pkg::MAP_RESET;
        end else if (wr && hit(wb_adr_i, bmr_pkg::OFS_MAP)) begin
            // caller must run from above the mirrored region while switching
            remap_sram <= wb_dat_i[bmr_pkg::MAP_BIT];
        end
    end

    // interrupt events, sticky, write one to clear, set wins
    assign irq_set = {bad_clr, sw_trig, wdt_expire, ext_fall};
    always_comb begin
        next_irq_sta = irq_sta;
        if (wr && hit(wb_adr_i, bmr_pkg::OFS_IRQ_STA)) begin
            next_irq_sta = irq_sta & ~wb_dat_i[3:0];
        end
        next_irq_sta = next_irq_sta | irq_set;
    end

    // interrupt status survives chip resets so the handler can see it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_sta <= bmr_pkg::IRQ_RESET;
            irq_mask <= bmr_pkg::IRQ_RESET;
            irq <= 1'b0;
        end else begin
            irq_sta <= next_irq_sta;
            if (wr && hit(wb_adr_i, bmr_pkg::OFS_IRQ_MASK)) begin
                irq_mask <= wb_dat_i[3:0];
            end
            irq <= |(irq_sta & irq_mask);
        end
    end

    // reset sequencer: hold core, run hidden kernel, branch to vector
    always_ff @(posedge ref_clk) begin
        if (rst || chip_trig) begin
            state <= bmr_pkg::BOOT_HOLD;
            cnt <= 10'h000;
            core_reset <= 1'b1;
            kernel_run <= 1'b0;
            vector_branch <= 1'b0;
        end else begin
            vector_branch <= 1'b0;
            case (state)
                bmr_pkg::BOOT_HOLD: begin
                    if (cnt == HOLD_LAST) begin
                        state <= bmr_pkg::BOOT_KERNEL;
                        cnt <= 10'h000;
                        core_reset <= 1'b0;
                        kernel_run <= 1'b1;
                    end else begin
                        cnt <= cnt + 10'h001;
                    end
                end
                bmr_pkg::BOOT_KERNEL: begin
                    // with the pin low the kernel keeps control (download mode)
                    if (cnt != KERNEL_LAST) begin
                        cnt <= cnt + 10'h001;
                    end else if (boot_sync) begin
                        state <= bmr_pkg::BOOT_RUN;
                        kernel_run <= 1'b0;
                        vector_branch <= 1'b1;
                    end
                end
                bmr_pkg::BOOT_RUN: begin
                    cnt <= 10'h000;
                end
                default: begin
                    state <= bmr_pkg::BOOT_HOLD;
                    cnt <= 10'h000;
                    core_reset <= 1'b1;
                    kernel_run <= 1'b0;
                end
            endcase
        end
    end

    // address decode, registered so every output is a flip-flop
    assign mirror_hit = (cpu_addr <= bmr_pkg::MIRROR_END);
    assign kernel_hit = (cpu_addr >= bmr_pkg::KERNEL_BASE)
        && (cpu_addr <= bmr_pkg::KERNEL_END);
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bottom_sram <= 1'b0;
            bottom_nvm <= 1'b0;
            kernel_sel <= 1'b0;
            kernel_fault <= 1'b0;
        end else begin
            bottom_sram <= mirror_hit & remap_sram;
            bottom_nvm <= mirror_hit & ~remap_sram;
            // kernel space only answers while the kernel itself runs
            kernel_sel <= kernel_hit & kernel_run;
            kernel_fault <= kernel_hit & ~kernel_run;
        end
    end

    // wishbone slave: one wait-free ack, unmapped reads return zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            wb_dat_o <= 32'h0000_0000;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
                if (hit(wb_adr_i, bmr_pkg::OFS_MAP)) begin
                    wb_dat_o <= {31'h0, remap_sram};
                end else if (hit(wb_adr_i, bmr_pkg::OFS_FLAGS)) begin
                    wb_dat_o <= {29'h0, flags};
                end else if (hit(wb_adr_i, bmr_pkg::OFS_IRQ_STA)) begin
                    wb_dat_o <= {28'h0, irq_sta};
                end else if (hit(wb_adr_i, bmr_pkg::OFS_IRQ_MASK)) begin
                    wb_dat_o <= {28'h0, irq_mask};
                end else if (hit(wb_adr_i, bmr_pkg::OFS_BOOT)) begin
                    wb_dat_o <= {28'h0, kernel_run, core_reset, state};
                end
            end
        end
    end
endmodule

// ==== bench/bmr_monitor.sv ====
// checker for the boot map and reset source block ports
`timescale 1ns/1ns
module bmr_monitor (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wdt_expire,
    input wire logic [31:0] cpu_addr,
    input wire logic core_reset,
    input wire logic kernel_run,
    input wire logic vector_branch,
    input wire logic remap_sram,
    input wire logic bottom_sram,
    input wire logic bottom_nvm,
    input wire logic kernel_sel,
    input wire logic kernel_fault
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // a request seen by the slave, and the write that forces a software reset
    sequence wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence sw_req;
        wb_req ##0 wb_we_i && wb_adr_i[7:2] == 6'h01 && wb_sel_i[0] && wb_dat_i[2];
    endsequence
    ack_answer_a: assert property (wb_req |=> wb_ack_o) else $error("ack missing");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("stray data");
    wdt_reset_a: assert property (wdt_expire |=> core_reset && !remap_sram)
        else $error("watchdog reset missed");
    sw_reset_a: assert property (sw_req |=> core_reset && !remap_sram)
        else $error("software reset missed");
    hold_len_a: assert property ($rose(core_reset) |-> core_reset[*5])
        else $error("hold too short");
    branch_a: assert property (vector_branch |-> $past(kernel_run) ##1 !vector_branch)
        else $error("bad branch pulse");
    kernel_hide_a: assert property (kernel_fault |-> !kernel_sel
        && $past(cpu_addr) >= bmr_pkg::KERNEL_BASE) else $error("bad kernel fault");
    mirror_a: assert property (bottom_sram || bottom_nvm |-> !(bottom_sram && bottom_nvm)
        && $past(cpu_addr) <= bmr_pkg::MIRROR_END) else $error("bad mirror decode");
endmodule

bind bmr_top bmr_monitor u_bmr_monitor (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wdt_expire, .cpu_addr,
    .core_reset, .kernel_run, .vector_branch, .remap_sram, .bottom_sram, .bottom_nvm,
    .kernel_sel, .kernel_fault);

// ==== bench/bmr_top_tb.sv ====
// self-checking bench for the boot map and reset source block
`timescale 1ns/1ns
module bmr_top_tb;
    logic ref_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ext_reset_n, boot_mode_pin;
    logic wdt_expire, core_reset, kernel_run, vector_branch, remap_sram, bottom_sram;
    logic bottom_nvm, kernel_sel, kernel_fault, irq;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, cpu_addr, q;
    int errors = 0;
    int checks = 0;
    bmr_top u_bmr_top (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_reset_n, .boot_mode_pin, .wdt_expire, .cpu_addr,
        .core_reset, .kernel_run, .vector_branch, .remap_sram, .bottom_sram, .bottom_nvm,
        .kernel_sel, .kernel_fault, .irq);
    initial begin
        ref_clk = 0;
        forever #20 ref_clk = ~ref_clk;
    end
    task final_report;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one classic cycle; ack is read before this edge's updates land
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        @(posedge ref_clk);
        while (wb_ack_o !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge ref_clk);
        if (n == 20) begin
            errors++;
            final_report;
        end
    endtask
    task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask
    // kernel must run its full length, then branch
    task boot_run;
        int n, i;
        n = 0;
        for (i = 0; i < 700; i++) begin
            @(posedge ref_clk);
            if (vector_branch === 1'b1) break;
            if (kernel_run === 1'b1) n++;
            // hidden kernel space answers only while the kernel itself runs
            if (n == 10) chk("kernel sel", 32'(cpu_addr == bmr_pkg::KERNEL_BASE), 32'(kernel_sel));
        end
        if (i == 700) begin
            errors++;
            final_report;
        end
        chk("kernel cycles", 32'(bmr_pkg::KERNEL_CYC), 32'(n));
    endtask
    task s_reset;
        boot_run;
        rd("flags", bmr_pkg::OFS_FLAGS, 32'h1);
        rd("map", bmr_pkg::OFS_MAP, 32'h0);
        rd("unmapped", 8'h3c, 32'h0);
    endtask
    task s_map;
        // map writes are issued while cpu_addr still lies inside the mirrored region
        wb(1'b1, bmr_pkg::OFS_MAP, 32'hffffffff);
        rd("map", bmr_pkg::OFS_MAP, 32'h1);
        cpu_addr <= 32'h20;
        repeat (2) @(posedge ref_clk);
        chk("bottom sram", 32'h1, 32'(bottom_sram));
        wb(1'b1, bmr_pkg::OFS_MAP, 32'h0);
        chk("bottom nvm", 32'h1, 32'(bottom_nvm));
        cpu_addr <= bmr_pkg::KERNEL_BASE;
        repeat (2) @(posedge ref_clk);
        chk("kernel fault", 32'h1, 32'(kernel_fault));
    endtask
    task s_sw;
        wb(1'b1, bmr_pkg::OFS_MAP, 32'h1);
        wb(1'b1, bmr_pkg::OFS_FLAGS, 32'h4);
        chk("sw reset", 32'h1, 32'({core_reset, remap_sram} == 2'b10));
        boot_run;
        rd("flags", bmr_pkg::OFS_FLAGS, 32'h5);
    endtask
    // sw status stays masked, wdt status raises irq until cleared
    task s_wdt;
        wb(1'b1, bmr_pkg::OFS_IRQ_MASK, 32'h2);
        chk("irq masked", 32'h0, 32'(irq));
        wdt_expire <= 1'b1;
        @(posedge ref_clk);
        wdt_expire <= 1'b0;
        boot_run;
        rd("flags", bmr_pkg::OFS_FLAGS, 32'h7);
        chk("irq set", 32'h1, 32'(irq));
        wb(1'b1, bmr_pkg::OFS_IRQ_STA, 32'h2);
        @(posedge ref_clk);
        chk("irq clear", 32'h0, 32'(irq));
    endtask
    task s_clr;
        wb(1'b1, bmr_pkg::OFS_CLEAR, 32'h3);
        chk("bad clear", 32'h1, 32'(core_reset));
        boot_run;
        rd("irq sta", bmr_pkg::OFS_IRQ_STA, 32'hc);
        rd("flags", bmr_pkg::OFS_FLAGS, 32'h4);
        wb(1'b1, bmr_pkg::OFS_CLEAR, 32'h4);
        rd("flags", bmr_pkg::OFS_FLAGS, 32'h0);
        chk("no reset", 32'h0, 32'(core_reset));
        ext_reset_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        ext_reset_n <= 1'b1;
        boot_run;
        rd("flags", bmr_pkg::OFS_FLAGS, 32'h0);
    endtask
    initial begin
        {rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = {1'b1, 43'h0};
        {ext_reset_n, boot_mode_pin, wdt_expire, cpu_addr, wb_sel_i} = {2'b11, 33'h0, 4'h1};
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        s_reset;
        s_map;
        s_sw;
        s_wdt;
        s_clr;
        final_report;
    end
endmodule
